// ### spl_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "spl_map.vh"

module spl_ctrl (
    // Clock and reset
    input wire SYS_CLK,
    input wire RST_B,
    // Host command port
    input wire CMD_VALID,
    input wire [2:0] CMD_CODE,
    input wire [`SPL_POS_W-1:0] CMD_VALUE,
    input wire [`SPL_SPD_W-1:0] CMD_SPEED,
    input wire [`SPL_IDX_W-1:0] CMD_IDX,
    // Host list write port
    input wire LIST_WR,
    input wire [`SPL_IDX_W-1:0] LIST_IDX,
    input wire [`SPL_POS_W-1:0] LIST_POS,
    input wire [`SPL_SPD_W-1:0] LIST_VAL,
    input wire LIST_SPEED_MODE,
    // Reference switch pin
    input wire REF_SW,
    // Power stage
    output reg STEP,
    output reg DIR,
    // Status
    output reg LIST_EVENT,
    output reg BUSY,
    output reg REFERENCED,
    output reg [`SPL_POS_W-1:0] AXIS_POS,
    // Teach-in store to parameter memory
    output reg TEACH_WR,
    output reg [`SPL_IDX_W-1:0] TEACH_IDX,
    output reg [`SPL_POS_W-1:0] TEACH_POS,
    output reg [`SPL_SPD_W-1:0] TEACH_VAL
);

// ==================================================
// States
localparam [2:0] ST_IDLE = 3'h1;
localparam [2:0] ST_MOVE = 3'h2;
localparam [2:0] ST_REF = 3'h4;

reg [2:0] state_q;
reg [`SPL_POS_W-1:0] abs_q;
reg [`SPL_POS_W-1:0] ref_q;
reg [`SPL_POS_W-1:0] target_q;
reg [`SPL_SPD_W-1:0] speed_q;
reg [`SPL_IDX_W-1:0] scan_q;
reg [`SPL_IDX_W-1:0] settle_q;
reg [`SPL_DEPTH-1:0] fired_q;
reg [`SPL_DEPTH-1:0] valid_q;
reg ref_s1_q;
reg ref_s2_q;

// List memory
reg [`SPL_POS_W-1:0] list_pos_m [0:`SPL_DEPTH-1];
reg [`SPL_SPD_W-1:0] list_val_m [0:`SPL_DEPTH-1];

// ==================================================
// Derived values
wire [`SPL_POS_W-1:0] axis_pos = abs_q - ref_q;
wire moving = (state_q == ST_MOVE) || (state_q == ST_REF);
wire [`SPL_SPD_W-1:0] move_period = (speed_q < `SPL_MIN_PERIOD) ? `SPL_MIN_PERIOD : speed_q;
wire [`SPL_SPD_W-1:0] period = (state_q == ST_REF) ? `SPL_REF_PERIOD : move_period;
wire tick;
wire at_target = (abs_q == target_q);
wire dir_up = $signed(target_q) > $signed(abs_q);
wire idle_cmd = CMD_VALID && (state_q == ST_IDLE);
wire scan_hit = moving && valid_q[scan_q] && !fired_q[scan_q]
                && (list_pos_m[scan_q] == axis_pos);

// Absolute target from zero point, relative from current position
wire [`SPL_POS_W-1:0] abs_target = ref_q + CMD_VALUE; // see R1
wire [`SPL_POS_W-1:0] rel_target = abs_q + CMD_VALUE; // see R1

spl_rate u_rate (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .run(moving && !(state_q == ST_MOVE && at_target)),
    .period(period),
    .tick(tick)
);

// ==================================================
// Reference switch synchroniser
always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
        ref_s1_q <= 1'b0;
        ref_s2_q <= 1'b0;
    end else begin
        ref_s1_q <= REF_SW;
        ref_s2_q <= ref_s1_q;
    end
end

// ==================================================
// List memory writes from host and teach-in
always @(posedge SYS_CLK) begin
    if (LIST_WR) begin // see R8
        list_pos_m[LIST_IDX] <= LIST_POS;
        list_val_m[LIST_IDX] <= LIST_VAL;
    end else if (idle_cmd && CMD_CODE == `SPL_CMD_TEACH) begin
        list_pos_m[CMD_IDX] <= axis_pos; // see R7
        list_val_m[CMD_IDX] <= CMD_SPEED; // see R7
    end
end

// ==================================================
// Motion sequencer
always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
        state_q <= ST_IDLE;
        abs_q <= 24'h000000;
        ref_q <= 24'h000000;
        target_q <= 24'h000000;
        speed_q <= `SPL_RESET_SPEED;
        settle_q <= 4'h0;
        REFERENCED <= 1'b0;
        DIR <= 1'b0;
        STEP <= 1'b0;
    end else begin
        STEP <= 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (CMD_VALID) begin
                    case (CMD_CODE)
                        `SPL_CMD_ABS: begin
                            target_q <= abs_target; // see R1
                            speed_q <= CMD_SPEED;
                            settle_q <= 4'h0;
                            state_q <= ST_MOVE;
                        end
                        `SPL_CMD_REL: begin
                            target_q <= rel_target; // see R1
                            speed_q <= CMD_SPEED;
                            settle_q <= 4'h0;
                            state_q <= ST_MOVE;
                        end
                        `SPL_CMD_REF: begin
                            DIR <= 1'b0; // see R2
                            state_q <= ST_REF;
                        end
                        `SPL_CMD_DIMSET: begin
                            ref_q <= abs_q; // see R3
                            REFERENCED <= 1'b1;
                        end
                        default: begin
                            state_q <= ST_IDLE;
                        end
                    endcase
                end
            end
            ST_MOVE: begin
                // Dwell one list sweep at the target so an entry there is seen
                if (at_target) begin
                    if (settle_q == 4'hf) begin // see R4
                        state_q <= ST_IDLE;
                    end else begin
                        settle_q <= settle_q + 4'h1;
                    end
                end else begin
                    DIR <= dir_up;
                    if (tick) begin
                        STEP <= 1'b1;
                        abs_q <= dir_up ? abs_q + 24'h000001 : abs_q - 24'h000001;
                    end
                end
                if (scan_hit && LIST_SPEED_MODE) begin
                    speed_q <= list_val_m[scan_q]; // see R6
                end
            end
            ST_REF: begin
                if (ref_s2_q) begin
                    ref_q <= abs_q; // see R2
                    REFERENCED <= 1'b1;
                    state_q <= ST_IDLE;
                end else if (tick) begin
                    STEP <= 1'b1;
                    abs_q <= abs_q - 24'h000001;
                end
            end
            default: begin
                state_q <= ST_IDLE;
            end
        endcase
    end
end

// ==================================================
// Background list comparison, one entry per cycle
always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
        scan_q <= 4'h0;
        fired_q <= 16'h0000;
        valid_q <= 16'h0000;
        LIST_EVENT <= 1'b0;
    end else begin
        scan_q <= scan_q + 4'h1; // see R4
        if (idle_cmd) begin
            fired_q <= 16'h0000;
        end else if (scan_hit) begin
            fired_q[scan_q] <= 1'b1; // see R4
        end
        if (LIST_WR) begin
            valid_q[LIST_IDX] <= 1'b1;
        end else if (idle_cmd && CMD_CODE == `SPL_CMD_TEACH) begin
            valid_q[CMD_IDX] <= 1'b1;
        end
        if (scan_hit && !LIST_SPEED_MODE) begin
            LIST_EVENT <= list_val_m[scan_q][0]; // see R5 see R9
        end
    end
end

// ==================================================
// Status and teach-in outputs
always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
        BUSY <= 1'b0;
        AXIS_POS <= 24'h000000;
        TEACH_WR <= 1'b0;
        TEACH_IDX <= 4'h0;
        TEACH_POS <= 24'h000000;
        TEACH_VAL <= 16'h0000;
    end else begin
        BUSY <= moving;
        AXIS_POS <= axis_pos;
        TEACH_WR <= idle_cmd && (CMD_CODE == `SPL_CMD_TEACH); // see R7
        if (idle_cmd && CMD_CODE == `SPL_CMD_TEACH) begin
            TEACH_IDX <= CMD_IDX;
            TEACH_POS <= axis_pos; // see R7
            TEACH_VAL <= CMD_SPEED;
        end
    end
end

endmodule // spl_ctrl
`default_nettype wire

// ### spl_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "spl_map.vh"

// ==================================================
// Port checker
module spl_ctrl_assertions (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // Command
    input wire logic CMD_VALID,
    input wire logic [2:0] CMD_CODE,
    input wire logic [`SPL_POS_W-1:0] CMD_VALUE,
    input wire logic [`SPL_SPD_W-1:0] CMD_SPEED,
    input wire logic [`SPL_IDX_W-1:0] CMD_IDX,
    // Outputs
    input wire logic STEP,
    input wire logic DIR,
    input wire logic LIST_EVENT,
    input wire logic BUSY,
    input wire logic REFERENCED,
    input wire logic [`SPL_POS_W-1:0] AXIS_POS,
    input wire logic TEACH_WR,
    input wire logic [`SPL_IDX_W-1:0] TEACH_IDX,
    input wire logic [`SPL_POS_W-1:0] TEACH_POS,
    input wire logic [`SPL_SPD_W-1:0] TEACH_VAL
);
    logic [7:0] gap_q;
    wire take = CMD_VALID && !BUSY;
    // Cycles since the last step, saturating
    always @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) gap_q <= 8'hff;
        else if (STEP) gap_q <= 8'h00;
        else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    property p_step_one; STEP |=> !STEP; endproperty
    a_step_one: assert property (p_step_one) else $error("step too long");
    property p_step_busy; STEP |-> BUSY && $stable(DIR); endproperty
    a_step_busy: assert property (p_step_busy) else $error("step while idle");
    property p_step_gap; STEP |-> gap_q >= 8'h1f; endproperty
    a_step_gap: assert property (p_step_gap) else $error("steps too close");
    property p_pos; $changed(AXIS_POS) |-> AXIS_POS - $past(AXIS_POS) == 24'h1
        || $past(AXIS_POS) - AXIS_POS == 24'h1 || AXIS_POS == 24'h0; endproperty
    a_pos: assert property (p_pos) else $error("position jump");
    property p_event; $changed(LIST_EVENT) |-> BUSY; endproperty
    a_event: assert property (p_event) else $error("event when idle");
    property p_dim; take && !$past(CMD_VALID) && CMD_CODE == `SPL_CMD_DIMSET
        |=> REFERENCED ##1 AXIS_POS == 24'h0 && !BUSY; endproperty
    a_dim: assert property (p_dim) else $error("dimension set");
    property p_teach; take && !$past(CMD_VALID) && CMD_CODE == `SPL_CMD_TEACH
        |=> TEACH_WR && TEACH_IDX == $past(CMD_IDX) && TEACH_VAL == $past(CMD_SPEED)
        && TEACH_POS == $past(AXIS_POS); endproperty
    a_teach: assert property (p_teach) else $error("teach store");
    property p_ref; $rose(REFERENCED) |-> ##[0:1] AXIS_POS == 24'h0; endproperty
    a_ref: assert property (p_ref) else $error("origin not zero");
    property p_move; take && !$past(CMD_VALID) && CMD_CODE == `SPL_CMD_ABS
        && CMD_SPEED <= 16'h0020 && CMD_VALUE != AXIS_POS |-> ##2 BUSY ##[28:34] STEP;
    endproperty
    a_move: assert property (p_move) else $error("move start");
endmodule // spl_ctrl_assertions

bind spl_ctrl spl_ctrl_assertions u_chk (.SYS_CLK, .RST_B, .CMD_VALID, .CMD_CODE, .CMD_VALUE,
    .CMD_SPEED, .CMD_IDX, .STEP, .DIR, .LIST_EVENT, .BUSY, .REFERENCED, .AXIS_POS,
    .TEACH_WR, .TEACH_IDX, .TEACH_POS, .TEACH_VAL);
`default_nettype wire

// ### spl_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "spl_map.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
    $display("Error %0t: got %0h want %0h", $time, a, e); end end

// ==================================================
// Testbench
module spl_ctrl_tb;
    logic SYS_CLK = 1'b0;
    logic RST_B = 1'b0;
    logic CMD_VALID = 1'b0;
    logic [2:0] CMD_CODE = 3'h0;
    logic [23:0] CMD_VALUE = 24'h0;
    logic [15:0] CMD_SPEED = 16'h0020;
    logic [3:0] CMD_IDX = 4'h0;
    logic LIST_WR = 1'b0;
    logic [3:0] LIST_IDX = 4'h0;
    logic [23:0] LIST_POS = 24'h0;
    logic [15:0] LIST_VAL = 16'h0;
    logic LIST_SPEED_MODE = 1'b0;
    wire REF_SW, STEP, DIR, LIST_EVENT, BUSY, REFERENCED, TEACH_WR;
    wire [23:0] AXIS_POS, TEACH_POS, stage_pos;
    wire [15:0] TEACH_VAL;
    wire [3:0] TEACH_IDX;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    int last = 0;
    int gap = 0;
    always #25 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) begin
        cyc++;
        if (STEP === 1'b1) begin
            gap = cyc - last;
            last = cyc;
        end
    end
    spl_ctrl dut (.SYS_CLK, .RST_B, .CMD_VALID, .CMD_CODE, .CMD_VALUE, .CMD_SPEED, .CMD_IDX,
        .LIST_WR, .LIST_IDX, .LIST_POS, .LIST_VAL, .LIST_SPEED_MODE, .REF_SW, .STEP, .DIR,
        .LIST_EVENT, .BUSY, .REFERENCED, .AXIS_POS, .TEACH_WR, .TEACH_IDX, .TEACH_POS,
        .TEACH_VAL);
    spl_stage stage (.clk(SYS_CLK), .rst_b(RST_B), .step(STEP), .dir(DIR), .ref_sw(REF_SW),
        .pos(stage_pos));
    task automatic strobe(input logic [2:0] c, input logic [23:0] v, input logic [15:0] s);
        @(posedge SYS_CLK);
        #1 {CMD_CODE, CMD_VALUE, CMD_SPEED, CMD_VALID} = {c, v, s, 1'b1};
        @(posedge SYS_CLK);
        #1 CMD_VALID = 1'b0;
    endtask
    task automatic cmd(input logic [2:0] c, input logic [23:0] v, input logic [15:0] s);
        int n;
        n = 0;
        strobe(c, v, s);
        repeat (3) @(posedge SYS_CLK);
        while (BUSY !== 1'b0 && n < 5000) begin
            @(posedge SYS_CLK);
            n++;
        end
        if (n >= 5000) begin
            miscompares++;
            $display("Error %0t: busy timeout", $time);
        end
        #1;
    endtask
    task automatic lw(input logic [3:0] i, input logic [23:0] p, input logic [15:0] v);
        @(posedge SYS_CLK);
        #1 {LIST_IDX, LIST_POS, LIST_VAL, LIST_WR} = {i, p, v, 1'b1};
        @(posedge SYS_CLK);
        #1 LIST_WR = 1'b0;
    endtask
    task automatic t_ref_abs;
        cmd(`SPL_CMD_REF, 24'h0, 16'h0100);
        `CHK(REFERENCED, 1'b1)
        `CHK(stage_pos, 24'hfffffd)
        cmd(`SPL_CMD_ABS, 24'h5, 16'h0020);
        `CHK(stage_pos, 24'h2)
        cmd(`SPL_CMD_ABS, 24'hfffffe, 16'h0020);
        `CHK(AXIS_POS, 24'hfffffe)
        `CHK(DIR, 1'b0)
        cmd(`SPL_CMD_REL, 24'h4, 16'h0020);
        `CHK(AXIS_POS, 24'h2)
        `CHK(stage_pos, 24'hffffff)
    endtask
    task automatic t_dim;
        cmd(`SPL_CMD_DIMSET, 24'h0, 16'h0020);
        `CHK(stage_pos, 24'hffffff)
        cmd(`SPL_CMD_ABS, 24'h3, 16'h0020);
        `CHK(stage_pos, 24'h2)
    endtask
    task automatic t_lists;
        lw(4'h0, 24'h5, 16'h0001);
        lw(4'h1, 24'h8, 16'h0000);
        cmd(`SPL_CMD_ABS, 24'h6, 16'h0020);
        `CHK(LIST_EVENT, 1'b1)
        cmd(`SPL_CMD_ABS, 24'h8, 16'h0020);
        `CHK(LIST_EVENT, 1'b0)
        LIST_SPEED_MODE = 1'b1;
        lw(4'h2, 24'ha, 16'h0040);
        cmd(`SPL_CMD_ABS, 24'hc, 16'h0020);
        `CHK(gap, 64)
        `CHK(AXIS_POS, 24'hc)
        `CHK(LIST_EVENT, 1'b0)
        LIST_SPEED_MODE = 1'b0;
    endtask
    task automatic t_teach_refuse;
        int l;
        CMD_IDX = 4'h3;
        cmd(`SPL_CMD_TEACH, 24'h0, 16'h0055);
        `CHK({TEACH_IDX, TEACH_POS, TEACH_VAL}, {4'h3, 24'hc, 16'h0055})
        strobe(`SPL_CMD_ABS, 24'h14, 16'h0020);
        repeat (40) @(posedge SYS_CLK);
        #1 `CHK(BUSY, 1'b1)
        cmd(`SPL_CMD_DIMSET, 24'h0, 16'h0020);
        cmd(3'h7, 24'h0, 16'h0020);
        `CHK(AXIS_POS, 24'h14)
        `CHK(stage_pos, 24'h13)
        l = last;
        cmd(`SPL_CMD_ABS, 24'h14, 16'h0020);
        `CHK(last, l)
    endtask
    task end_of_test;
        $display("Checks %0d, miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #3000000;
        miscompares++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge SYS_CLK);
        #1 RST_B = 1'b1;
        t_ref_abs();
        t_dim();
        t_lists();
        t_teach_refuse();
        end_of_test();
    end
endmodule // spl_ctrl_tb
`default_nettype wire

// ### spl_map.vh
// Behaviour
// R1: Point-to-point target: absolute from zero, or relative.
// R2: Referencing move to switch sets the origin.
// R3: Dimension setting takes current position as reference.
// R4: List positions compared in background during moves.
// R5: Signal list entry drives list-event output level.
// R6: Speed list entry changes travel speed, continues moving.
// R7: Teach-in stores measured position with value.
// R8: Host writes list entries over accepted command paths; the code writes them through the separate LIST_WR port in any state.
// R9: List-event output holds level between list hits.
`ifndef SPL_MAP_VH
`define SPL_MAP_VH

// ==================================================
// Widths
`define SPL_POS_W 24
`define SPL_SPD_W 16
`define SPL_IDX_W 4
`define SPL_DEPTH 16

// ==================================================
// Command codes
`define SPL_CMD_ABS 3'h1
`define SPL_CMD_REL 3'h2
`define SPL_CMD_REF 3'h3
`define SPL_CMD_DIMSET 3'h4
`define SPL_CMD_TEACH 3'h5

// ==================================================
// Timing counts, in clock cycles per step
`define SPL_MIN_PERIOD 16'h0020
`define SPL_REF_PERIOD 16'h0100
`define SPL_RESET_SPEED 16'h0100

`endif

// ### spl_rate.v
`timescale 1ns/1ps
`default_nettype none
`include "spl_map.vh"

module spl_rate (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Control
    input wire run,
    input wire [`SPL_SPD_W-1:0] period,
    // Step enable
    output reg tick
);

// ==================================================
// Divider producing one enable pulse per period
reg [`SPL_SPD_W-1:0] cnt_q;

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        cnt_q <= 16'h0000;
        tick <= 1'b0;
    end else if (!run) begin
        cnt_q <= 16'h0000;
        tick <= 1'b0;
    end else if (cnt_q >= period - 16'h0001) begin
        cnt_q <= 16'h0000;
        tick <= 1'b1;
    end else begin
        cnt_q <= cnt_q + 16'h0001;
        tick <= 1'b0;
    end
end

endmodule // spl_rate
`default_nettype wire

// ### spl_stage.sv
`timescale 1ns/1ps
`default_nettype none

// ==================================================
// Power stage and axis with reference switch
module spl_stage #(parameter logic signed [23:0] REF_AT = -24'sd3) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Step input
    input wire logic step,
    input wire logic dir,
    // Axis
    output logic ref_sw,
    output logic [23:0] pos
);
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) pos <= 24'h0;
        else if (step) pos <= dir ? pos + 24'h1 : pos - 24'h1;
    end
    // Switch closed at and beyond the reference mark
    assign ref_sw = $signed(pos) <= REF_AT;
endmodule // spl_stage
`default_nettype wire
